//--- bench/pmrb_bank_props.sv
// Checker for the transceiver management register bank ports
`timescale 1ns/1ps
`default_nettype none
module pmrb_bank_props #(
  parameter int CountWidth = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic linkSpeed100,
  input wire logic autonegEnable,
  input wire logic autonegRestart,
  input wire logic heartbeatActive,
  input wire logic [15:0] advertWord
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic rdValid_q;
  logic [7:0] rdAddr_q;
  // Address of the read whose data shows this cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdValid_q <= 1'b0;
      rdAddr_q <= 8'h00;
    end else begin
      rdValid_q <= regRead;
      rdAddr_q <= regAddr;
    end
  end
  a_unmapped_zero: assert property (
    rdValid_q && rdAddr_q == 8'h60 |-> regRdata == 16'h0000)
    else $error("unmapped read returned data");
  a_status_caps: assert property (
    rdValid_q && rdAddr_q == pmrb_pkg::OffStatus
    |-> regRdata[15:11] == 5'h0f && regRdata[10:6] == 5'h00 && regRdata[0])
    else $error("status capability bits wrong");
  a_exp_upper_zero: assert property (
    rdValid_q && rdAddr_q == pmrb_pkg::OffExpansion |-> regRdata[15:5] == 11'h000)
    else $error("expansion upper bits not zero");
  a_ctl_reset_clear: assert property (
    rdValid_q && rdAddr_q == pmrb_pkg::OffControl
    |-> regRdata[15:14] == 2'b00 && regRdata[7:0] == 8'h00)
    else $error("control reset or reserved bit reads one");
  a_test_reserved: assert property (
    rdValid_q && rdAddr_q == pmrb_pkg::OffTest
    |-> regRdata[15:8] == 8'h00 && regRdata[6:4] == 3'h0)
    else $error("test register reserved bits set");
  a_advert_fixed: assert property (
    advertWord[15:14] == 2'b00 && advertWord[12:11] == 2'b00 && !advertWord[9])
    else $error("advertisement fixed bits wrong");
  a_restart_cause: assert property (
    regWrite && regAddr == pmrb_pkg::OffControl && regWdata[9] && !regWdata[15]
    |-> ##[1:3] autonegRestart)
    else $error("restart pulse missing");
  a_restart_pulse: assert property (autonegRestart |=> !autonegRestart)
    else $error("restart longer than one cycle");
  a_speed_ignored: assert property (autonegEnable |-> !linkSpeed100)
    else $error("speed bit used under autoneg");
  a_heartbeat_10m: assert property (heartbeatActive |-> !linkSpeed100)
    else $error("heartbeat active at 100 Mbps");
  c_restart: cover property (autonegRestart);
  c_fault_read: cover property (rdValid_q && rdAddr_q == pmrb_pkg::OffStatus && regRdata[4]);
  c_page_read: cover property (rdValid_q && rdAddr_q == pmrb_pkg::OffExpansion && regRdata[1]);
endmodule
bind pmrb_phy_mgmt_register_bank pmrb_bank_props #(.CountWidth(CountWidth)) pmrb_bank_props_inst (
  .clk, .reset_n, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .linkSpeed100,
  .autonegEnable, .autonegRestart, .heartbeatActive, .advertWord);
`default_nettype wire

//--- bench/pmrb_link_partner.sv
// Remote link partner model: page words and remote fault
`timescale 1ns/1ps
`default_nettype none
module pmrb_link_partner (
  input wire logic clk,
  input wire logic sendPage,
  input wire logic [15:0] pageWord,
  input wire logic faultReq,
  output logic pageReceived,
  output logic [15:0] partnerWord,
  output logic remoteFault
);
  int hold;
  initial begin
    hold = 0;
    pageReceived = 1'b0;
    partnerWord = 16'h0000;
    remoteFault = 1'b0;
  end
  always @(posedge clk) begin
    pageReceived <= sendPage;
    remoteFault <= faultReq;
    if (sendPage) begin
      partnerWord <= pageWord;
      hold <= 4;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end else begin
      // Word not valid outside a page
      partnerWord <= ~partnerWord;
    end
  end
endmodule
`default_nettype wire

//--- bench/test_phy_mgmt_register_bank.sv
// Self-checking bench for the transceiver management register bank
`timescale 1ns/1ps
`default_nettype none
module test_phy_mgmt_register_bank;
  localparam int CW = 8;
  logic clk = 0, reset_n = 0, regWrite = 0, regRead = 0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000, pageWord = 16'h0000, w, e;
  logic eeSpeed = 1, eeAutoneg = 0, eeDuplex = 1, eeNoPause = 0;
  logic anComplete = 0, resolvedDuplex = 0, linkUp = 0, jabberSeen = 0, multiLinkFault = 0;
  logic partnerAutonegCapable = 0, abilityDetect = 0, parallelFault = 0, linkCheck = 0;
  logic sendPage = 0, faultReq = 0;
  logic [2:0] ev = 3'b000;
  logic pageReceived, remoteFault, linkSpeed100, fullDuplex, autonegEnable, autonegRestart;
  logic autonegLoopback, ledLinkpulseSelect, heartbeatActive, jabberEnable;
  logic [15:0] regRdata, partnerWord, advertWord;
  logic [15:0] mdl [logic [7:0]], dflt [logic [7:0]];
  logic [7:0] wa [4] = '{8'h62, 8'h66, 8'h70, 8'h74};
  logic [7:0] zs [7] = '{8'h68, 8'h6a, 8'h6c, 8'h6e, 8'h72, 8'h60, 8'h76};
  logic [7:0] co [3] = '{8'h6c, 8'h6e, 8'h72};
  logic [31:0] r = 32'h5774;
  int error_cnt = 0, check_count = 0, cyc = 0, rstCnt = 0, n;
  pmrb_phy_mgmt_register_bank #(.CountWidth(CW)) pmrb_phy_mgmt_register_bank_inst (
    .clk, .reset_n, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .eeSpeed,
    .eeAutoneg, .eeDuplex, .eeNoPause, .anComplete, .resolvedDuplex, .linkUp, .jabberSeen,
    .remoteFault, .pageReceived, .partnerWord, .multiLinkFault, .partnerAutonegCapable,
    .abilityDetect, .parallelFault, .linkCheck, .disconnectEvent(ev[0]),
    .falseCarrierEvent(ev[1]), .rxErrorEvent(ev[2]), .linkSpeed100, .fullDuplex,
    .autonegEnable, .autonegRestart, .autonegLoopback, .ledLinkpulseSelect,
    .heartbeatActive, .jabberEnable, .advertWord);
  pmrb_link_partner pmrb_link_partner_inst (.clk, .sendPage, .pageWord, .faultReq,
    .pageReceived, .partnerWord, .remoteFault);
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (autonegRestart === 1'b1) rstCnt++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [15:0] wm(input logic [7:0] a);
    case (a)
      8'h62: return 16'h3100;
      8'h66: return 16'h21ff;
      8'h70: return 16'h0088;
      default: return 16'h0180;
    endcase
  endfunction
  function automatic logic [15:0] ex(input logic [7:0] a);
    ex = mdl[a];
    if (a == 8'h62 && mdl[a][12]) ex[8] = resolvedDuplex;
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    check_count++;
    if (s !== x) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    regWrite = 1;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regWrite = 0;
    if (mdl.exists(a)) mdl[a] = (mdl[a] & ~wm(a)) | (d & wm(a));
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] x);
    logic [15:0] m;
    m = (a == 8'h74) ? 16'h0180 : 16'hffff;
    @(negedge clk);
    regRead = 1;
    regAddr = a;
    @(negedge clk);
    regRead = 0;
    chk(regRdata & m, x & m);
  endtask
  task automatic outs;
    logic [15:0] c, t;
    c = mdl[8'h62];
    t = mdl[8'h74];
    chk(linkSpeed100, c[13] & ~c[12]);
    chk(fullDuplex, c[12] ? resolvedDuplex : c[8]);
    chk(autonegEnable, c[12]);
    chk(advertWord, mdl[8'h66]);
    chk({autonegLoopback, ledLinkpulseSelect}, {mdl[8'h70][7], mdl[8'h70][3]});
    chk({heartbeatActive, jabberEnable}, {t[8] & ~(c[13] & ~c[12]), t[7]});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    dflt[8'h62] = 16'h2100;
    dflt[8'h66] = 16'h05e1;
    dflt[8'h70] = 16'h0000;
    dflt[8'h74] = 16'h0180;
    mdl = dflt;
    repeat (20) @(negedge clk);
    reset_n = 1;
    repeat (4) @(negedge clk);
    foreach (wa[i]) rc(wa[i], mdl[wa[i]]);
    foreach (zs[i]) rc(zs[i], 16'h0000);
    rc(8'h64, 16'h7809);
    outs;
    $display("defaults done");
    repeat (8) begin
      r = lfsr(r);
      resolvedDuplex = r[20];
      wr(wa[r[17:16]], r[15:0] & 16'h7dff);
      rc(wa[r[17:16]], ex(wa[r[17:16]]));
      outs;
    end
    wr(8'h62, mdl[8'h62] | 16'h0200);
    repeat (4) @(negedge clk);
    chk(rstCnt, 1);
    rc(8'h62, ex(8'h62));
    $display("writes done");
    foreach (co[k]) begin
      r = lfsr(r);
      n = r[2:0] % 5 + 1;
      repeat (n) begin
        @(negedge clk) ev[k] = 1;
        @(negedge clk) ev[k] = 0;
      end
      repeat (4) @(negedge clk);
      rc(co[k], n);
      rc(co[k], 16'h0000);
    end
    @(negedge clk) ev[0] = 1;
    repeat (258) @(negedge clk);
    ev[0] = 0;
    repeat (4) @(negedge clk);
    rc(8'h6c, 258 % (1 << CW));
    $display("counters done");
    linkUp = 1;
    jabberSeen = 1;
    anComplete = 1;
    @(negedge clk) faultReq = 1;
    @(negedge clk) faultReq = 0;
    repeat (6) @(negedge clk);
    rc(8'h64, 16'h783f);
    rc(8'h64, 16'h782f);
    linkUp = 0;
    jabberSeen = 0;
    anComplete = 0;
    repeat (6) @(negedge clk);
    rc(8'h64, 16'h7801);
    $display("status done");
    r = lfsr(r);
    w = r[15:0];
    pageWord = w;
    w = w & 16'he7ff;
    multiLinkFault = 1;
    partnerAutonegCapable = 1;
    @(negedge clk) sendPage = 1;
    @(negedge clk) sendPage = 0;
    repeat (8) @(negedge clk);
    e = {11'h000, 1'b1, w[15], 1'b0, 1'b1, 1'b1};
    rc(8'h6a, e);
    rc(8'h68, w);
    rc(8'h6a, e & 16'hfffd);
    wr(8'h68, ~w);
    rc(8'h68, w);
    $display("page done");
    abilityDetect = 1;
    parallelFault = 1;
    linkCheck = 1;
    repeat (4) @(negedge clk);
    rc(8'h70, mdl[8'h70] | 16'h0007);
    abilityDetect = 0;
    parallelFault = 0;
    linkCheck = 0;
    wr(8'h66, 16'h0000);
    wr(8'h62, 16'h8000);
    mdl = dflt;
    repeat (4) @(negedge clk);
    foreach (wa[i]) rc(wa[i], ex(wa[i]));
    outs;
    $display("soft reset done");
    final_report;
  end
endmodule
`default_nettype wire

//--- hw/pmrb_counter.sv
// Wrapping event counter that clears on read
`timescale 1ns/1ps
`default_nettype none
module pmrb_counter #(
  parameter int Width = 16
) (
  input wire logic clk,
  input wire logic resetN,
  input wire logic softReset,
  input wire logic event_i,
  input wire logic readClear,
  output logic [Width-1:0] count_q
);
  // Event in the clearing cycle is kept as a count of one
  logic [Width-1:0] count_d;
  assign count_d = softReset ? '0 :
    readClear ? {{(Width-1){1'b0}}, event_i} :
    count_q + {{(Width-1){1'b0}}, event_i};
  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule
`default_nettype wire

//--- hw/pmrb_phy_mgmt_register_bank.sv
// Transceiver management register bank with word register port and PHY event inputs
//
// How it works
// RQ1: Writing control bit 15 resets all bank registers, then clears itself.
// RQ2: Control bit 13 picks 100 or 10 Mbps; initial value from EEPROM.
// RQ3: With autoneg enabled speed bit ignored; else speed and duplex bits rule.
// RQ4: Writing control bit 9 restarts auto-negotiation.
// RQ5: Duplex bit reads resolved status under autoneg, else written value.
// RQ6: Status capability bits are fixed read-only values.
// RQ7: Status bit 5 shows auto-negotiation complete.
// RQ8: Status bit 4 sets on remote fault, clears on status read.
// RQ9: Status bit 3 reads one until a link failure is seen.
// RQ10: Status bits 2 and 1 show link valid and jabber; both reset zero.
// RQ11: Advertisement selector defaults to CSMA/CD code and is writable.
// RQ12: Advertisement media bits writable default one; T4 zero; remote fault writable.
// RQ13: Advertisement pause bit is read-only, default from EEPROM.
// RQ14: Partner ability register is read-only capture of received word.
// RQ15: Page-received flag sets on new page, clears on partner ability read.
// RQ16: Expansion upper bits zero; bits 4, 3, 0 show fault and partner abilities.
// RQ17: Disconnect counter 16 bits, counts events, wraps, clears on read.
// RQ18: False carrier counter 16 bits, resets zero, clears on read.
// RQ19: Receive error counter 16 bits, resets zero, clears on read.
// RQ20: Test bit 7 selects autoneg loopback, bit 3 LED link pulses.
// RQ21: Read-only test flags record ability detect, parallel fault, link check.
// RQ22: Heartbeat enable defaults one, acts only at 10 Mbps; jabber enable defaults one.
// RQ23: Writes to read-only or reserved bits do nothing; reserved bits read zero.
`timescale 1ns/1ps
`default_nettype none
module pmrb_phy_mgmt_register_bank #(
  parameter int CountWidth = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  input wire logic eeSpeed,
  input wire logic eeAutoneg,
  input wire logic eeDuplex,
  input wire logic eeNoPause,
  input wire logic anComplete,
  input wire logic resolvedDuplex,
  input wire logic linkUp,
  input wire logic jabberSeen,
  input wire logic remoteFault,
  input wire logic pageReceived,
  input wire logic [15:0] partnerWord,
  input wire logic multiLinkFault,
  input wire logic partnerAutonegCapable,
  input wire logic abilityDetect,
  input wire logic parallelFault,
  input wire logic linkCheck,
  input wire logic disconnectEvent,
  input wire logic falseCarrierEvent,
  input wire logic rxErrorEvent,
  output logic linkSpeed100,
  output logic fullDuplex,
  output logic autonegEnable,
  output logic autonegRestart,
  output logic autonegLoopback,
  output logic ledLinkpulseSelect,
  output logic heartbeatActive,
  output logic jabberEnable,
  output logic [15:0] advertWord
);
  logic rstMeta_q;
  logic rstSync_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  wire resetN = rstSync_q;

  // Pin-level status from the transceiver core
  localparam int NumPins = 30;
  logic [NumPins-1:0] pinRaw;
  logic [NumPins-1:0] pinSync;
  assign pinRaw = {anComplete, resolvedDuplex, linkUp, jabberSeen, remoteFault, pageReceived,
    partnerWord, multiLinkFault, partnerAutonegCapable, abilityDetect, parallelFault,
    linkCheck, disconnectEvent, falseCarrierEvent, rxErrorEvent};
  pmrb_sync #(.Width(NumPins)) pinSyncer (
    .clk(clk),
    .resetN(resetN),
    .asyncIn(pinRaw),
    .syncOut(pinSync)
  );
  wire sComplete = pinSync[29];
  wire sResolvedDuplex = pinSync[28];
  wire sLink = pinSync[27];
  wire sJabber = pinSync[26];
  wire sRemoteFault = pinSync[25];
  wire sPage = pinSync[24];
  wire [15:0] sPartner = pinSync[23:8];
  wire sMultiFault = pinSync[7];
  wire sPartnerAn = pinSync[6];
  wire sAbility = pinSync[5];
  wire sParallel = pinSync[4];
  wire sLinkCheck = pinSync[3];
  wire sDisconnect = pinSync[2];
  wire sFalseCarrier = pinSync[1];
  wire sRxError = pinSync[0];

  // Straps are sampled once after reset release
  logic strapTaken_q;
  logic eeSpeed_q;
  logic eeAutoneg_q;
  logic eeDuplex_q;
  logic eePause_q;

  // Address decode
  wire selControl = regAddr == pmrb_pkg::OffControl;
  wire selStatus = regAddr == pmrb_pkg::OffStatus;
  wire selAdvert = regAddr == pmrb_pkg::OffAdvert;
  wire selPartner = regAddr == pmrb_pkg::OffPartner;
  wire selExpansion = regAddr == pmrb_pkg::OffExpansion;
  wire selDisconnect = regAddr == pmrb_pkg::OffDisconnect;
  wire selFalseCarrier = regAddr == pmrb_pkg::OffFalseCarrier;
  wire selTest = regAddr == pmrb_pkg::OffTest;
  wire selRxError = regAddr == pmrb_pkg::OffRxError;
  wire selCsConfig = regAddr == pmrb_pkg::OffCsConfig;

  wire softReset = regWrite && selControl && regWdata[pmrb_pkg::CtlReset]; // [RQ1]
  wire loadDefaults = softReset || !strapTaken_q;

  logic speed_q;
  logic autoneg_q;
  logic duplex_q;
  logic restart_q;
  logic remoteFault_q;
  logic noFail_q;
  logic linkSeen_q;
  logic advRemoteFault_q;
  logic [3:0] advMedia_q;
  logic [4:0] advSelector_q;
  logic [15:0] partner_q;
  logic pageRx_q;
  logic multiFault_q;
  logic loopback_q;
  logic ledPulse_q;
  logic [2:0] testFlags_q;
  logic heartbeat_q;
  logic jabberEn_q;
  logic [CountWidth-1:0] disconnectCount;
  logic [CountWidth-1:0] falseCarrierCount;
  logic [CountWidth-1:0] rxErrorCount;

  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      strapTaken_q <= 1'b0;
      eeSpeed_q <= 1'b0;
      eeAutoneg_q <= 1'b0;
      eeDuplex_q <= 1'b0;
      eePause_q <= 1'b0;
    end else if (!strapTaken_q) begin
      strapTaken_q <= 1'b1;
      eeSpeed_q <= eeSpeed;
      eeAutoneg_q <= eeAutoneg;
      eeDuplex_q <= eeDuplex;
      eePause_q <= !eeNoPause; // [RQ13]
    end
  end

  wire wrControl = regWrite && selControl && !softReset;
  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      speed_q <= 1'b0;
      autoneg_q <= 1'b0;
      duplex_q <= 1'b0;
      restart_q <= 1'b0;
    end else if (loadDefaults) begin
      speed_q <= strapTaken_q ? eeSpeed_q : eeSpeed; // [RQ2]
      autoneg_q <= strapTaken_q ? eeAutoneg_q : eeAutoneg;
      duplex_q <= strapTaken_q ? eeDuplex_q : eeDuplex;
      restart_q <= 1'b0;
    end else begin
      restart_q <= wrControl && regWdata[pmrb_pkg::CtlRestart]; // [RQ4]
      if (wrControl) begin
        speed_q <= regWdata[pmrb_pkg::CtlSpeed];
        autoneg_q <= regWdata[pmrb_pkg::CtlAutoneg];
        duplex_q <= regWdata[pmrb_pkg::CtlDuplex];
      end
    end
  end

  wire rdStatus = regRead && selStatus;
  wire rdPartner = regRead && selPartner;
  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      remoteFault_q <= 1'b0;
      noFail_q <= 1'b1;
      pageRx_q <= 1'b0;
      partner_q <= '0;
      multiFault_q <= 1'b0;
      testFlags_q <= '0;
    end else if (softReset) begin
      remoteFault_q <= 1'b0;
      noFail_q <= 1'b1;
      pageRx_q <= 1'b0;
      partner_q <= '0;
      multiFault_q <= 1'b0;
      testFlags_q <= '0;
    end else begin
      remoteFault_q <= sRemoteFault || (remoteFault_q && !rdStatus); // [RQ8]
      noFail_q <= noFail_q && !(linkSeen_q && !sLink); // [RQ9]
      pageRx_q <= sPage || (pageRx_q && !rdPartner); // [RQ15]
      if (sPage) begin
        partner_q <= sPartner; // [RQ14]
      end
      multiFault_q <= multiFault_q || sMultiFault;
      testFlags_q <= testFlags_q | {sAbility, sParallel, sLinkCheck}; // [RQ21]
    end
  end

  // Link fail means a drop after a link was once up
  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      linkSeen_q <= 1'b0;
    end else if (softReset) begin
      linkSeen_q <= 1'b0;
    end else if (sLink) begin
      linkSeen_q <= 1'b1;
    end
  end

  wire wrAdvert = regWrite && selAdvert && !loadDefaults;
  wire wrTest = regWrite && selTest && !loadDefaults;
  wire wrCs = regWrite && selCsConfig && !loadDefaults;
  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      advRemoteFault_q <= 1'b0;
      advMedia_q <= pmrb_pkg::AdvMediaReset;
      advSelector_q <= pmrb_pkg::SelectorCsmaCd;
      loopback_q <= 1'b0;
      ledPulse_q <= 1'b0;
      heartbeat_q <= 1'b1;
      jabberEn_q <= 1'b1;
    end else if (softReset) begin
      advRemoteFault_q <= 1'b0;
      advMedia_q <= pmrb_pkg::AdvMediaReset; // [RQ12]
      advSelector_q <= pmrb_pkg::SelectorCsmaCd; // [RQ11]
      loopback_q <= 1'b0;
      ledPulse_q <= 1'b0;
      heartbeat_q <= 1'b1; // [RQ22]
      jabberEn_q <= 1'b1;
    end else begin
      if (wrAdvert) begin
        advRemoteFault_q <= regWdata[pmrb_pkg::AdvRemoteFault]; // [RQ12]
        advMedia_q <= regWdata[pmrb_pkg::AdvMediaHi:pmrb_pkg::AdvMediaLo];
        advSelector_q <= regWdata[4:0]; // [RQ11]
      end
      if (wrTest) begin
        loopback_q <= regWdata[pmrb_pkg::TstLoopback]; // [RQ20]
        ledPulse_q <= regWdata[pmrb_pkg::TstLedPulse];
      end
      if (wrCs) begin
        heartbeat_q <= regWdata[pmrb_pkg::CsHeartbeat];
        jabberEn_q <= regWdata[pmrb_pkg::CsJabber];
      end
    end
  end

  pmrb_counter #(.Width(CountWidth)) disconnectCounter (
    .clk(clk),
    .resetN(resetN),
    .softReset(softReset),
    .event_i(sDisconnect),
    .readClear(regRead && selDisconnect),
    .count_q(disconnectCount)
  ); // [RQ17]
  pmrb_counter #(.Width(CountWidth)) falseCarrierCounter (
    .clk(clk),
    .resetN(resetN),
    .softReset(softReset),
    .event_i(sFalseCarrier),
    .readClear(regRead && selFalseCarrier),
    .count_q(falseCarrierCount)
  ); // [RQ18]
  pmrb_counter #(.Width(CountWidth)) rxErrorCounter (
    .clk(clk),
    .resetN(resetN),
    .softReset(softReset),
    .event_i(sRxError),
    .readClear(regRead && selRxError),
    .count_q(rxErrorCount)
  ); // [RQ19]

  // Read word assembly; reserved bits are zero
  wire duplexView = autoneg_q ? sResolvedDuplex : duplex_q; // [RQ5]
  wire [15:0] controlView = {2'b00, speed_q, autoneg_q, 2'b00, 1'b0, duplexView, 8'h00};
  wire [15:0] statusView = pmrb_pkg::StatusCaps |
    {10'h000, sComplete, remoteFault_q, noFail_q, sLink, sJabber, 1'b0}; // [RQ6] [RQ7] [RQ10]
  wire [15:0] advertView = {2'b00, advRemoteFault_q, 2'b00, eePause_q, 1'b0, advMedia_q,
    advSelector_q}; // [RQ13]
  wire [15:0] expansionView = {11'h000, multiFault_q, partner_q[15], 1'b0, pageRx_q,
    sPartnerAn}; // [RQ16]
  wire [15:0] testView = {8'h00, loopback_q, 3'b000, ledPulse_q, testFlags_q};
  wire [15:0] csView = {7'h00, heartbeat_q, jabberEn_q, 7'h00};
  logic [15:0] readMux;
  always_comb begin
    readMux = 16'h0000;
    if (selControl) begin
      readMux = controlView;
    end else if (selStatus) begin
      readMux = statusView;
    end else if (selAdvert) begin
      readMux = advertView;
    end else if (selPartner) begin
      readMux = partner_q & 16'he7ff; // [RQ23]
    end else if (selExpansion) begin
      readMux = expansionView;
    end else if (selDisconnect) begin
      readMux = 16'(disconnectCount);
    end else if (selFalseCarrier) begin
      readMux = 16'(falseCarrierCount);
    end else if (selTest) begin
      readMux = testView;
    end else if (selRxError) begin
      readMux = 16'(rxErrorCount);
    end else if (selCsConfig) begin
      readMux = csView; // [RQ23]
    end
  end

  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      regRdata <= 16'h0000;
      linkSpeed100 <= 1'b0;
      fullDuplex <= 1'b0;
      autonegEnable <= 1'b0;
      autonegRestart <= 1'b0;
      autonegLoopback <= 1'b0;
      ledLinkpulseSelect <= 1'b0;
      heartbeatActive <= 1'b0;
      jabberEnable <= 1'b0;
      advertWord <= 16'h0000;
    end else begin
      regRdata <= regRead ? readMux : 16'h0000;
      linkSpeed100 <= autoneg_q ? 1'b0 : speed_q; // [RQ3]
      fullDuplex <= duplexView;
      autonegEnable <= autoneg_q;
      autonegRestart <= restart_q;
      autonegLoopback <= loopback_q;
      ledLinkpulseSelect <= ledPulse_q;
      heartbeatActive <= heartbeat_q && !(autoneg_q ? 1'b0 : speed_q); // [RQ22]
      jabberEnable <= jabberEn_q;
      advertWord <= advertView;
    end
  end
endmodule
`default_nettype wire

//--- hw/pmrb_pkg.sv
// Package: register offsets, bit positions and reset values of the transceiver bank
package pmrb_pkg;
  localparam int AddrWidth = 8;
  localparam logic [7:0] OffControl = 8'h62;
  localparam logic [7:0] OffStatus = 8'h64;
  localparam logic [7:0] OffAdvert = 8'h66;
  localparam logic [7:0] OffPartner = 8'h68;
  localparam logic [7:0] OffExpansion = 8'h6a;
  localparam logic [7:0] OffDisconnect = 8'h6c;
  localparam logic [7:0] OffFalseCarrier = 8'h6e;
  localparam logic [7:0] OffTest = 8'h70;
  localparam logic [7:0] OffRxError = 8'h72;
  localparam logic [7:0] OffCsConfig = 8'h74;
  // Control bit positions
  localparam int CtlReset = 15;
  localparam int CtlSpeed = 13;
  localparam int CtlAutoneg = 12;
  localparam int CtlRestart = 9;
  localparam int CtlDuplex = 8;
  // Status bit positions
  localparam int StsComplete = 5;
  localparam int StsRemoteFault = 4;
  localparam int StsNoFail = 3;
  localparam int StsLink = 2;
  localparam int StsJabber = 1;
  // Fixed capability bits of basic mode status
  localparam logic [15:0] StatusCaps = 16'h7801;
  // Advertisement fields
  localparam int AdvRemoteFault = 13;
  localparam int AdvPause = 10;
  localparam int AdvMediaLo = 5;
  localparam int AdvMediaHi = 8;
  localparam logic [3:0] AdvMediaReset = 4'hf;
  localparam logic [4:0] SelectorCsmaCd = 5'h01;
  // Expansion bit positions
  localparam int ExpMultiFault = 4;
  localparam int ExpPartnerNp = 3;
  localparam int ExpPageRx = 1;
  localparam int ExpPartnerAn = 0;
  // Test register bit positions
  localparam int TstLoopback = 7;
  localparam int TstLedPulse = 3;
  // Carrier-sense configuration bit positions
  localparam int CsHeartbeat = 8;
  localparam int CsJabber = 7;
  localparam logic [15:0] CounterReset = 16'h0000;
endpackage

//--- hw/pmrb_sync.sv
// Two-flop synchroniser for a bundle of pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module pmrb_sync #(
  parameter int Width = 1
) (
  input wire logic clk,
  input wire logic resetN,
  input wire logic [Width-1:0] asyncIn,
  output logic [Width-1:0] syncOut
);
  logic [Width-1:0] stage1_q;
  always_ff @(posedge clk or negedge resetN) begin
    if (!resetN) begin
      stage1_q <= '0;
      syncOut <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end
endmodule
`default_nettype wire
